// ### hdl/vpa_pkg.sv
// Shared constants and types for the picture adjust and control stage.
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package vpa_pkg;
	// Register offsets.
	localparam logic [7:0] VPA_OFS_FORMAT   = 8'h01;
	localparam logic [7:0] VPA_OFS_CTRL     = 8'h04;
	localparam logic [7:0] VPA_OFS_CONTRAST = 8'h06;
	localparam logic [7:0] VPA_OFS_BRIGHT   = 8'h07;
	localparam logic [7:0] VPA_OFS_SAT      = 8'h08;
	localparam logic [7:0] VPA_OFS_HUE      = 8'h09;
	localparam logic [7:0] VPA_OFS_REQUEST  = 8'h0a;
	localparam logic [7:0] VPA_OFS_LIMIT    = 8'h0b;
	localparam logic [7:0] VPA_OFS_STATUS   = 8'h10;
	localparam logic [7:0] VPA_OFS_DONE     = 8'h11;
	localparam logic [7:0] VPA_OFS_CAP_LO   = 8'h12;
	localparam logic [7:0] VPA_OFS_CAP_HI   = 8'h13;
	localparam logic [7:0] VPA_OFS_EXT_LO   = 8'h14;
	localparam logic [7:0] VPA_OFS_EXT_HI   = 8'h15;
	localparam logic [7:0] VPA_OFS_ID_LO    = 8'h16;
	localparam logic [7:0] VPA_OFS_ID_HI    = 8'h17;
	// Reset values.
	localparam logic [7:0] VPA_RST_CTRL     = 8'h00;
	localparam logic [7:0] VPA_RST_CONTRAST = 8'h80;
	localparam logic [7:0] VPA_RST_BRIGHT   = 8'h00;
	localparam logic [7:0] VPA_RST_SAT      = 8'h80;
	localparam logic [7:0] VPA_RST_HUE      = 8'h00;
	// Control register fields.
	localparam int VPA_BIT_PIVOT   = 7;
	localparam int VPA_BIT_PSAVE   = 6;
	localparam int VPA_BIT_PARITY  = 5;
	localparam int VPA_BIT_RATE_HI = 4;
	localparam int VPA_BIT_RATE_LO = 3;
	// Request and done bit positions, low end of their registers.
	localparam int VPA_REQ_CAP = 0;
	localparam int VPA_REQ_EXT = 1;
	localparam int VPA_REQ_ID  = 2;
	// Status register holds the done flags at its top bits.
	localparam int VPA_STS_CAP = 5;
	localparam int VPA_STS_EXT = 6;
	localparam int VPA_STS_ID  = 7;
	// Arithmetic constants.
	localparam logic [11:0] VPA_PIVOT_IN   = 12'h080;
	localparam logic [11:0] VPA_OFFSET_MID = 12'h07d;
	localparam logic [11:0] VPA_OFFSET_LOW = 12'h010;
	localparam logic [11:0] VPA_CLIP_MIN   = 12'h001;
	localparam logic [11:0] VPA_CLIP_MAX   = 12'h0fe;
	localparam logic [11:0] VPA_LIM_MIN    = 12'h010;
	localparam logic [11:0] VPA_LIM_MAX    = 12'h0eb;
	localparam int          VPA_GAIN_SHIFT = 7;
	// One hue step of about 0.35 degree in radians, scaled by 2^14.
	localparam logic signed [7:0] VPA_HUE_STEP = 8'sh64;
	localparam int          VPA_HUE_SHIFT  = 14;
	localparam logic [7:0]  VPA_BLACK_Y    = 8'h10;
	localparam logic [7:0]  VPA_BLACK_C    = 8'h80;
	// Line windows and capture lines.
	localparam logic [9:0] VPA_N_ACT1_LO = 10'h016;
	localparam logic [9:0] VPA_N_ACT1_HI = 10'h105;
	localparam logic [9:0] VPA_N_ACT2_LO = 10'h11d;
	localparam logic [9:0] VPA_N_ACT2_HI = 10'h20c;
	localparam logic [9:0] VPA_P_ACT1_LO = 10'h017;
	localparam logic [9:0] VPA_P_ACT1_HI = 10'h136;
	localparam logic [9:0] VPA_P_ACT2_LO = 10'h150;
	localparam logic [9:0] VPA_P_ACT2_HI = 10'h26f;
	localparam logic [9:0] VPA_LINE_CAP  = 10'h015;
	localparam logic [9:0] VPA_LINE_EXT  = 10'h11c;
	localparam logic [9:0] VPA_LINE_ID1  = 10'h014;
	localparam logic [9:0] VPA_LINE_ID2  = 10'h11b;
	localparam logic [9:0] VPA_LINE_WSS  = 10'h017;
	localparam logic [5:0] VPA_CRC_INIT  = 6'h3f;
	// Frame rate codes and output formats.
	typedef enum logic [1:0] {
		VPA_RATE_FULL    = 2'b00,
		VPA_RATE_HALF    = 2'b01,
		VPA_RATE_QUARTER = 2'b10,
		VPA_RATE_RSVD    = 2'b11
	} vpa_rate_t;
	localparam logic [2:0] VPA_FMT_QVGA = 3'h0;
	localparam logic [2:0] VPA_FMT_CIF  = 3'h2;
	localparam logic [2:0] VPA_FMT_QCIF = 3'h3;
endpackage

// ### hdl/vpa_luma.sv
// Luma contrast, brightness and clipping pipeline, two cycles deep.
`timescale 1ns/1ps
module vpa_luma
	import vpa_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_reset,
	input  wire logic [7:0] i_luma_input,
	input  wire logic [7:0] i_contrast_gain,
	input  wire logic [7:0] i_brightness_offset,
	input  wire logic       i_contrast_pivot_sel,
	input  wire logic       i_range_limit,
	output logic      [7:0] o_luma_result
);
	logic signed [11:0] contrast_r;
	logic signed [19:0] prod;
	logic signed [11:0] sum;
	logic signed [11:0] lo;
	logic signed [11:0] hi;

	// Contrast stage; the product keeps 7 fraction bits, gain 0x80 is unity.
	// contrast gain
	always_comb begin
		prod = ($signed({4'h0, i_luma_input}) - $signed(VPA_PIVOT_IN))
			* $signed({12'h000, i_contrast_gain});
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			contrast_r <= 12'sh000;
		end else begin
			contrast_r <= prod[18:7] + $signed(i_contrast_pivot_sel ?
				VPA_OFFSET_LOW : VPA_OFFSET_MID);
		end
	end

	// Brightness on the adjusted sample, then one clip at the end.
	// signed brightness add
	always_comb begin
		sum = contrast_r + {{4{i_brightness_offset[7]}}, i_brightness_offset};
		lo  = $signed(i_range_limit ? VPA_LIM_MIN : VPA_CLIP_MIN);
		hi  = $signed(i_range_limit ? VPA_LIM_MAX : VPA_CLIP_MAX);
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_luma_result <= VPA_BLACK_Y;
		end else if (sum < lo) begin
			o_luma_result <= lo[7:0];
		end else if (sum > hi) begin
			o_luma_result <= hi[7:0];
		end else begin
			o_luma_result <= sum[7:0];
		end
	end
endmodule

// ### hdl/vpa_chroma.sv
// Chroma saturation, demodulation and hue rotation, two cycles deep.
`timescale 1ns/1ps
module vpa_chroma
	import vpa_pkg::*;
(
	input  wire logic              i_mclk,
	input  wire logic              i_reset,
	input  wire logic signed [7:0] i_chroma,
	input  wire logic signed [7:0] i_carrier_cos,
	input  wire logic signed [7:0] i_carrier_sin,
	input  wire logic        [7:0] i_saturation_gain,
	input  wire logic signed [7:0] i_hue_rotation,
	output logic             [7:0] o_cb,
	output logic             [7:0] o_cr
);
	logic signed [9:0]  sat_r;
	logic signed [7:0]  cos_r;
	logic signed [7:0]  sin_r;
	logic signed [18:0] sat_prod;
	logic signed [17:0] u_full;
	logic signed [17:0] v_full;
	logic signed [27:0] u_turn;
	logic signed [27:0] v_turn;
	logic signed [11:0] u_out;
	logic signed [11:0] v_out;

	// Saturation scales the raw chroma before it is demodulated.
	// saturation before demodulation
	always_comb begin
		sat_prod = i_chroma * $signed({1'b0, i_saturation_gain});
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			sat_r <= 10'sh000;
			cos_r <= 8'sh00;
			sin_r <= 8'sh00;
		end else begin
			sat_r <= sat_prod[16:7];
			cos_r <= i_carrier_cos;
			sin_r <= i_carrier_sin;
		end
	end

	// Small-angle rotation: within 45 degrees the error stays modest and
	// it saves a sine table.
	// hue rotation
	always_comb begin
		u_full = sat_r * cos_r;
		v_full = sat_r * sin_r;
		u_turn = $signed(u_full[17:7]) * i_hue_rotation * VPA_HUE_STEP;
		v_turn = $signed(v_full[17:7]) * i_hue_rotation * VPA_HUE_STEP;
		u_out  = 12'sh080 + {u_full[17], u_full[17:7]} - v_turn[25:14];
		v_out  = 12'sh080 + {v_full[17], v_full[17:7]} + u_turn[25:14];
	end

	// Clip to the legal code range around the 0x80 centre.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_cb <= VPA_BLACK_C;
			o_cr <= VPA_BLACK_C;
		end else begin
			o_cb <= (u_out < 12'sh001) ? 8'h01 :
				(u_out > 12'sh0fe) ? 8'hfe : u_out[7:0];
			o_cr <= (v_out < 12'sh001) ? 8'h01 :
				(v_out > 12'sh0fe) ? 8'hfe : v_out[7:0];
		end
	end
endmodule

// ### hdl/vpa_top.sv
// Picture adjust, frame rate control and caption capture stage.
`timescale 1ns/1ps
module vpa_top
	import vpa_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	// Host sub-address register port.
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	output logic      [7:0]  o_reg_rdata,
	output logic             o_reg_rvalid,
	// Decoded samples and timing from the separation stage.
	input  wire logic        i_sample_valid,
	input  wire logic [7:0]  i_luma_input,
	input  wire logic [7:0]  i_chroma,
	input  wire logic [7:0]  i_carrier_cos,
	input  wire logic [7:0]  i_carrier_sin,
	input  wire logic        i_cb_not_cr,
	input  wire logic [9:0]  i_line_num,
	input  wire logic        i_field_even,
	input  wire logic        i_frame_start,
	input  wire logic        i_std_625,
	// Vertical-interval data words from the slicer.
	input  wire logic        i_vbi_valid,
	input  wire logic [19:0] i_vbi_word,
	// Pixel output.
	output logic             o_pix_valid,
	output logic      [7:0]  o_luma_result,
	output logic      [7:0]  o_chroma_out,
	output logic             o_active,
	output logic             o_low_power
);
	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	logic [7:0]  ctrl_r;
	logic [7:0]  contrast_r;
	logic [7:0]  bright_r;
	logic [7:0]  sat_r;
	logic [7:0]  hue_r;
	logic [2:0]  format_r;
	logic        limit_r;
	logic [2:0]  pending_r;
	logic [2:0]  done_r;
	logic [15:0] cap_data_r;
	logic [15:0] ext_data_r;
	logic [13:0] id_data_r;
	logic [2:0]  req_wr;
	logic [2:0]  decoded;

	// Request strobes come only from a write to the request register.
	assign req_wr = (i_reg_wr && i_reg_addr == VPA_OFS_REQUEST) ?
		i_reg_wdata[2:0] : 3'h0;

	// Control and adjustment settings.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			ctrl_r     <= VPA_RST_CTRL;
			contrast_r <= VPA_RST_CONTRAST;
			bright_r   <= VPA_RST_BRIGHT;
			sat_r      <= VPA_RST_SAT;
			hue_r      <= VPA_RST_HUE;
			format_r   <= 3'h0;
			limit_r    <= 1'b0;
		end else if (i_reg_wr) begin
			unique case (i_reg_addr)
				VPA_OFS_CTRL:     ctrl_r     <= i_reg_wdata;
				VPA_OFS_CONTRAST: contrast_r <= i_reg_wdata;
				VPA_OFS_BRIGHT:   bright_r   <= i_reg_wdata;
				VPA_OFS_SAT:      sat_r      <= i_reg_wdata;
				VPA_OFS_HUE:      hue_r      <= i_reg_wdata;
				VPA_OFS_FORMAT:   format_r   <= i_reg_wdata[2:0];
				VPA_OFS_LIMIT:    limit_r    <= i_reg_wdata[0];
				default: begin
				end
			endcase
		end
	end

	// Read port answers one cycle after the strobe; unmapped reads zero.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_reg_rdata  <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) begin
				unique case (i_reg_addr)
					VPA_OFS_FORMAT:   o_reg_rdata <= {5'h00, format_r};
					VPA_OFS_CTRL:     o_reg_rdata <= ctrl_r;
					VPA_OFS_CONTRAST: o_reg_rdata <= contrast_r;
					VPA_OFS_BRIGHT:   o_reg_rdata <= bright_r;
					VPA_OFS_SAT:      o_reg_rdata <= sat_r;
					VPA_OFS_HUE:      o_reg_rdata <= hue_r;
					VPA_OFS_LIMIT:    o_reg_rdata <= {7'h00, limit_r};
					VPA_OFS_STATUS:   o_reg_rdata <= {done_r, 5'h00};
					VPA_OFS_DONE:     o_reg_rdata <= {5'h00, done_r};
					VPA_OFS_CAP_LO:   o_reg_rdata <= cap_data_r[7:0];
					VPA_OFS_CAP_HI:   o_reg_rdata <= cap_data_r[15:8];
					VPA_OFS_EXT_LO:   o_reg_rdata <= ext_data_r[7:0];
					VPA_OFS_EXT_HI:   o_reg_rdata <= ext_data_r[15:8];
					VPA_OFS_ID_LO:    o_reg_rdata <= {2'h0, id_data_r[13:8]};
					VPA_OFS_ID_HI:    o_reg_rdata <= id_data_r[7:0];
					default:          o_reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Frame rate, field and power control
	// ------------------------------------------------------------------
	vpa_rate_t   rate;
	logic [1:0]  frame_cnt_r;
	logic [1:0]  valid_pipe_r;
	logic        frame_keep;
	logic        field_ok;
	logic        progressive;

	assign rate = vpa_rate_t'({ctrl_r[VPA_BIT_RATE_HI],
		ctrl_r[VPA_BIT_RATE_LO]});

	// Frame counter advances once per input frame.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			frame_cnt_r <= 2'h0;
		end else if (i_frame_start) begin
			frame_cnt_r <= frame_cnt_r + 2'h1;
		end
	end

	// The reserved code runs at full rate rather than freezing the picture.
	// rate decimation
	always_comb begin
		unique case (rate)
			VPA_RATE_HALF:    frame_keep = (frame_cnt_r[0] == 1'b0);
			VPA_RATE_QUARTER: frame_keep = (frame_cnt_r == 2'h0);
			default:          frame_keep = 1'b1;
		endcase
	end

	assign progressive = (format_r == VPA_FMT_QVGA) ||
		(format_r == VPA_FMT_CIF) || (format_r == VPA_FMT_QCIF);
	assign field_ok = !progressive ||
		(i_field_even == ctrl_r[VPA_BIT_PARITY]);

	// Power save only ever engages when frames are actually being skipped,
	// and waits for the pixel pipeline to drain so no kept pixel is cut.
	// power save
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_low_power <= 1'b0;
		end else begin
			o_low_power <= ctrl_r[VPA_BIT_PSAVE] &&
				(rate != VPA_RATE_FULL) && !frame_keep &&
				(valid_pipe_r == 2'h0);
		end
	end

	// ------------------------------------------------------------------
	// Line windows
	// ------------------------------------------------------------------
	function automatic logic vpa_is_active(input logic [9:0] line,
		input logic std_625);
		if (std_625) begin
			vpa_is_active = (line >= VPA_P_ACT1_LO && line <= VPA_P_ACT1_HI)
				|| (line >= VPA_P_ACT2_LO && line <= VPA_P_ACT2_HI);
		end else begin
			vpa_is_active = (line >= VPA_N_ACT1_LO && line <= VPA_N_ACT1_HI)
				|| (line >= VPA_N_ACT2_LO && line <= VPA_N_ACT2_HI);
		end
	endfunction

	// ------------------------------------------------------------------
	// Sample pipeline
	// ------------------------------------------------------------------
	logic [7:0] luma_adj;
	logic [7:0] cb_adj;
	logic [7:0] cr_adj;
	logic [1:0] active_pipe_r;
	logic [1:0] sel_pipe_r;

	vpa_luma u_luma (
		.i_mclk               (i_mclk),
		.i_reset              (i_reset),
		.i_luma_input         (i_luma_input),
		.i_contrast_gain      (contrast_r),
		.i_brightness_offset  (bright_r),
		.i_contrast_pivot_sel (ctrl_r[VPA_BIT_PIVOT]),
		.i_range_limit        (limit_r),
		.o_luma_result        (luma_adj)
	);

	vpa_chroma u_chroma (
		.i_mclk            (i_mclk),
		.i_reset           (i_reset),
		.i_chroma          (i_chroma),
		.i_carrier_cos     (i_carrier_cos),
		.i_carrier_sin     (i_carrier_sin),
		.i_saturation_gain (sat_r),
		.i_hue_rotation    (hue_r),
		.o_cb              (cb_adj),
		.o_cr              (cr_adj)
	);

	// Timing flags travel beside the two-cycle arithmetic.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			valid_pipe_r  <= 2'h0;
			active_pipe_r <= 2'h0;
			sel_pipe_r    <= 2'h0;
		end else begin
			valid_pipe_r  <= {valid_pipe_r[0],
				i_sample_valid && frame_keep && field_ok};
			active_pipe_r <= {active_pipe_r[0],
				vpa_is_active(i_line_num, i_std_625)};
			sel_pipe_r    <= {sel_pipe_r[0], i_cb_not_cr};
		end
	end

	// Output register; blanking lines carry black.
	// black in blanking
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_pix_valid   <= 1'b0;
			o_active      <= 1'b0;
			o_luma_result <= VPA_BLACK_Y;
			o_chroma_out  <= VPA_BLACK_C;
		end else begin
			o_pix_valid <= valid_pipe_r[1];
			o_active    <= active_pipe_r[1];
			if (active_pipe_r[1]) begin
				o_luma_result <= luma_adj;
				o_chroma_out  <= sel_pipe_r[1] ? cb_adj : cr_adj;
			end else begin
				o_luma_result <= VPA_BLACK_Y;
				o_chroma_out  <= VPA_BLACK_C;
			end
		end
	end

	// ------------------------------------------------------------------
	// Vertical-interval capture
	// ------------------------------------------------------------------
	function automatic logic [5:0] vpa_crc6(input logic [13:0] data);
		logic [5:0] crc;
		logic       fb;
		crc = VPA_CRC_INIT;
		for (int i = 13; i >= 0; i--) begin
			fb  = crc[5] ^ data[i];
			crc = {crc[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
		end
		vpa_crc6 = crc;
	endfunction

	logic crc_good;

	assign crc_good = (vpa_crc6(i_vbi_word[19:6]) == i_vbi_word[5:0]);

	always_comb begin
		decoded = 3'h0;
		if (i_vbi_valid) begin
			if (!i_std_625) begin
				decoded[VPA_REQ_CAP] = (i_line_num == VPA_LINE_CAP);
				decoded[VPA_REQ_EXT] = (i_line_num == VPA_LINE_EXT);
				decoded[VPA_REQ_ID]  = crc_good &&
					(i_line_num == VPA_LINE_ID1 ||
					i_line_num == VPA_LINE_ID2);
			end else begin
				decoded[VPA_REQ_ID]  = (i_line_num == VPA_LINE_WSS);
			end
		end
		decoded = decoded & pending_r;
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			pending_r <= 3'h0;
		end else begin
			pending_r <= (pending_r & ~decoded) | req_wr;
		end
	end

	// A decode in the clearing cycle still reports done.
	// done flags
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			done_r <= 3'h7;
		end else begin
			done_r <= (done_r & ~req_wr) | decoded;
		end
	end

	// Result words change only on a decode that was asked for.
	// result storage
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			cap_data_r <= 16'h0000;
			ext_data_r <= 16'h0000;
			id_data_r  <= 14'h0000;
		end else begin
			if (decoded[VPA_REQ_CAP]) begin
				cap_data_r <= i_vbi_word[15:0];
			end
			if (decoded[VPA_REQ_EXT]) begin
				ext_data_r <= i_vbi_word[15:0];
			end
			if (decoded[VPA_REQ_ID]) begin
				id_data_r <= i_std_625 ? i_vbi_word[13:0] :
					i_vbi_word[19:6];
			end
		end
	end
endmodule

// ### verif/vpa_assertions.sv
// Port checker for the picture adjust stage.
`timescale 1ns/1ps
module vpa_assertions (
	input wire logic       i_mclk,
	input wire logic       i_reset,
	input wire logic       i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	input wire logic       o_reg_rvalid,
	input wire logic [9:0] i_line_num,
	input wire logic       i_std_625,
	input wire logic       o_pix_valid,
	input wire logic [7:0] o_luma_result,
	input wire logic [7:0] o_chroma_out,
	input wire logic       o_active,
	input wire logic       o_low_power
);
	// ------------------------------
	// Line window
	// ------------------------------
	logic act_now;
	// Taken from the input line; outputs follow three edges later.
	assign act_now = i_std_625 ?
		(i_line_num inside {[10'h017:10'h136], [10'h150:10'h26f]}) :
		(i_line_num inside {[10'h016:10'h105], [10'h11d:10'h20c]});
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);
	a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
		else $error("Read unanswered.");
	a_read_quiet: assert property (!i_reg_rd |=> !o_reg_rvalid)
		else $error("Spurious read valid.");
	a_rdata_hold: assert property (
		!o_reg_rvalid |-> $stable(o_reg_rdata)) else $error("Data moved.");
	a_blank_black: assert property (
		!act_now |-> ##3 (o_luma_result == 8'h10 && o_chroma_out == 8'h80
		&& !o_active)) else $error("Blanking not black.");
	a_active_set: assert property (act_now |-> ##3 o_active)
		else $error("Active line not flagged.");
	a_luma_clip: assert property (
		o_active |-> o_luma_result inside {[8'h01:8'hfe]})
		else $error("Luma out of range.");
	a_chroma_clip: assert property (
		o_active |-> o_chroma_out inside {[8'h01:8'hfe]})
		else $error("Chroma out of range.");
	a_save_idle: assert property (o_low_power |-> !o_pix_valid)
		else $error("Output while saving.");
endmodule
bind vpa_top vpa_assertions u_chk (.i_mclk, .i_reset, .i_reg_rd,
	.o_reg_rdata, .o_reg_rvalid, .i_line_num, .i_std_625, .o_pix_valid,
	.o_luma_result, .o_chroma_out, .o_active, .o_low_power);

// ### verif/vpa_video_source.sv
// Line timing source standing in for the separation stage.
`timescale 1ns/1ps
module vpa_video_source #(
	parameter int CYC_PER_LINE = 2
) (
	input  wire logic       i_mclk,
	input  wire logic       i_reset,
	input  wire logic       i_hold,
	input  wire logic       i_std_625,
	output logic      [9:0] o_line_num,
	output logic            o_field_even,
	output logic            o_frame_start
);
	logic [3:0] cyc_r;
	logic [9:0] last;
	assign last = i_std_625 ? 10'h271 : 10'h20d;
	// line numbering
	// Hold freezes the line so a sample can sit in one place for a while.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			cyc_r <= 4'h0;
			o_line_num <= 10'h001;
			o_frame_start <= 1'b0;
		end else begin
			o_frame_start <= 1'b0;
			if (!i_hold && cyc_r == 4'(CYC_PER_LINE - 1)) begin
				cyc_r <= 4'h0;
				o_frame_start <= (o_line_num == last);
				o_line_num <= (o_line_num == last) ? 10'h001 :
					o_line_num + 10'h001;
			end else if (!i_hold) begin
				cyc_r <= cyc_r + 4'h1;
			end
		end
	end
	// Second field starts after line 263 or 312.
	assign o_field_even = o_line_num > (i_std_625 ? 10'h138 : 10'h107);
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the picture adjust stage.
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [7:0] ctl, con, bri, lim, y, ey, saturation_gain, hue, c, cb, ec;
	} vpa_row_t;
	logic        i_mclk, i_reset, i_reg_wr, i_reg_rd, o_reg_rvalid;
	logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, i_luma_input;
	logic [7:0]  i_chroma, i_carrier_cos, i_carrier_sin;
	logic [7:0]  o_luma_result, o_chroma_out, np, nl;
	logic        i_sample_valid, i_cb_not_cr, i_field_even, i_frame_start;
	logic        i_std_625, i_vbi_valid, o_pix_valid, o_active;
	logic        o_low_power, hold, sp, sl;
	logic [9:0]  i_line_num;
	logic [19:0] i_vbi_word;
	logic [13:0] p = 14'h2b3c;
	int          error_cnt = 0;
	int          compares = 0;
	// Rows: ctl con bri lim y ey sat hue c cb ec.
	vpa_row_t    rows [12] = '{
		88'h00_80_00_00_80_7d_80_00_00_01_80,
		88'h00_80_00_00_c8_c5_80_00_40_01_bf,
		88'h00_ff_00_00_ff_fe_80_00_40_00_80,
		88'h00_80_00_00_00_01_40_00_40_01_9f,
		88'h80_80_00_00_80_10_40_10_40_00_83,
		88'h80_40_00_00_c8_34_80_00_c0_01_40,
		88'h00_80_0a_00_80_87_80_00_00_01_80,
		88'h00_80_81_00_80_01_80_00_00_01_80,
		88'h00_80_00_01_ff_eb_80_00_00_01_80,
		88'h00_80_00_01_00_10_80_00_00_01_80,
		88'h00_40_40_00_ff_fc_80_00_00_01_80,
		88'h00_40_00_00_00_3d_80_00_00_01_80};
	// Reset values {addr, value, mask}; 0x3f is unmapped.
	logic [23:0] rst_tab [10] = '{24'h0400ff, 24'h0680ff, 24'h0700ff,
		24'h0880ff, 24'h0900ff, 24'h0a00ff, 24'h0b0001, 24'h10e0e0,
		24'h110707, 24'h3f00ff};
	// Rate rows {control, kept frames of 4, saving frames of 4}.
	logic [23:0] rt [5] = '{24'h400400, 24'h480202, 24'h500103,
		24'h580400, 24'h080200};
	// Clock at 200 MHz.
	always #2.5 i_mclk = ~i_mclk;
	vpa_top dut (.i_mclk, .i_reset, .i_reg_wr, .i_reg_rd, .i_reg_addr,
		.i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_sample_valid,
		.i_luma_input, .i_chroma, .i_carrier_cos, .i_carrier_sin,
		.i_cb_not_cr, .i_line_num, .i_field_even, .i_frame_start,
		.i_std_625, .i_vbi_valid, .i_vbi_word, .o_pix_valid,
		.o_luma_result, .o_chroma_out, .o_active, .o_low_power);
	vpa_video_source src (.i_mclk, .i_reset, .i_hold(hold), .i_std_625,
		.o_line_num(i_line_num), .o_field_even(i_field_even),
		.o_frame_start(i_frame_start));
	// ------------------------------
	// Tasks
	// ------------------------------
	// Every task starts and ends just after a rising edge.
	task automatic step;
		@(posedge i_mclk);
		#1;
	endtask
	task automatic complete_run;
		$display("Compares %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic tmo;
		error_cnt++;
		$display("MISMATCH t=%0t wait ran out", $time);
		complete_run();
	endtask
	task automatic check(input logic [7:0] got, exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, v);
		i_reg_wr = 1'b1;
		i_reg_addr = a;
		i_reg_wdata = v;
		step();
		i_reg_wr = 1'b0;
		step();
	endtask
	// A read strobe lasts one cycle; the answer is awaited with a bound.
	task automatic chk(input logic [7:0] a, exp, m);
		int k;
		i_reg_rd = 1'b1;
		i_reg_addr = a;
		for (k = 0; k < 4 && o_reg_rvalid !== 1'b1; k++) begin
			step();
			i_reg_rd = 1'b0;
		end
		if (k == 4)
			tmo();
		check(o_reg_rdata & m, exp & m);
		step();
	endtask
	task automatic wait_line(input logic [9:0] n);
		int k;
		hold = 1'b0;
		for (k = 0; k < 3000 && i_line_num !== n; k++)
			step();
		if (k == 3000)
			tmo();
		hold = 1'b1;
	endtask
	task automatic vbi(input logic [19:0] w);
		i_vbi_word = w;
		i_vbi_valid = 1'b1;
		step();
		i_vbi_valid = 1'b0;
		step();
	endtask
	// Only odd-field active lines count, so pipeline lag cannot spill over.
	task automatic frame(output logic fp, fl);
		int k;
		fp = 1'b0;
		fl = 1'b0;
		for (k = 0; k < 2000 && i_frame_start !== 1'b1; k++) begin
			step();
			if (i_line_num inside {[10'h016:10'h105]}) begin
				fp = fp | (o_pix_valid === 1'b1);
				fl = fl | (o_low_power === 1'b1);
			end
		end
		if (k == 2000)
			tmo();
		step();
	endtask
	function automatic logic [5:0] crc6(input logic [13:0] v);
		logic [5:0] r;
		r = 6'h3f;
		for (int i = 13; i >= 0; i--)
			r = {r[4:0], 1'b0} ^ ((v[i] ^ r[5]) ? 6'h03 : 6'h00);
		return r;
	endfunction
	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		i_mclk = 1'b0;
		i_reset = 1'b1;
		{i_reg_wr, i_reg_rd, i_vbi_valid, hold, i_std_625} = 5'h00;
		{i_reg_addr, i_reg_wdata, i_chroma, i_carrier_sin} = 32'h0;
		i_carrier_cos = 8'h7f;
		i_luma_input = 8'h80;
		i_sample_valid = 1'b1;
		i_cb_not_cr = 1'b1;
		i_vbi_word = 20'h00000;
		repeat (6) @(posedge i_mclk);
		#1 i_reset = 1'b0;
		foreach (rst_tab[i])
			chk(rst_tab[i][23:16], rst_tab[i][15:8], rst_tab[i][7:0]);
		$display("Reset values done.");
		wait_line(10'h064);
		foreach (rows[i]) begin
			wr(8'h04, rows[i].ctl);
			wr(8'h06, rows[i].con);
			wr(8'h07, rows[i].bri);
			wr(8'h0b, rows[i].lim);
			wr(8'h08, rows[i].saturation_gain);
			wr(8'h09, rows[i].hue);
			i_luma_input = rows[i].y;
			i_chroma = rows[i].c;
			i_cb_not_cr = rows[i].cb[0];
			repeat (4) step();
			check(o_luma_result, rows[i].ey);
			check(o_chroma_out, rows[i].ec);
		end
		$display("Adjust rows done.");
		check({7'h00, o_pix_valid}, 8'h01);
		wr(8'h04, 8'h20);
		repeat (4) step();
		check({7'h00, o_pix_valid}, 8'h00);
		wr(8'h01, 8'h01);
		repeat (4) step();
		check({7'h00, o_pix_valid}, 8'h01);
		wr(8'h01, 8'h00);
		wr(8'h04, 8'h00);
		$display("Field select done.");
		wr(8'h0a, 8'h07);
		chk(8'h10, 8'h00, 8'he0);
		wait_line(10'h014);
		vbi({p, ~crc6(p)});
		chk(8'h10, 8'h00, 8'he0);
		wait_line(10'h015);
		vbi(20'h0a5c3);
		wait_line(10'h11b);
		vbi({p, crc6(p)});
		wait_line(10'h11c);
		vbi(20'h03c5a);
		hold = 1'b0;
		chk(8'h10, 8'he0, 8'he0);
		chk(8'h11, 8'h07, 8'h07);
		chk(8'h12, 8'hc3, 8'hff);
		chk(8'h13, 8'ha5, 8'hff);
		chk(8'h14, 8'h5a, 8'hff);
		chk(8'h15, 8'h3c, 8'hff);
		chk(8'h16, 8'h2b, 8'hff);
		chk(8'h17, 8'h3c, 8'hff);
		wr(8'h0a, 8'h01);
		chk(8'h10, 8'hc0, 8'he0);
		chk(8'h12, 8'hc3, 8'hff);
		$display("Capture done.");
		i_std_625 = 1'b1;
		wr(8'h0a, 8'h04);
		chk(8'h10, 8'h40, 8'he0);
		wait_line(10'h136);
		repeat (3) step();
		check({7'h00, o_active}, 8'h01);
		wait_line(10'h017);
		vbi(20'h01d2b);
		hold = 1'b0;
		chk(8'h10, 8'hc0, 8'he0);
		chk(8'h16, 8'h1d, 8'hff);
		chk(8'h17, 8'h2b, 8'hff);
		i_std_625 = 1'b0;
		$display("Wide screen done.");
		foreach (rt[i]) begin
			wr(8'h04, rt[i][23:16]);
			frame(sp, sl);
			np = 8'h00;
			nl = 8'h00;
			repeat (4) begin
				frame(sp, sl);
				np = np + {7'h00, sp};
				nl = nl + {7'h00, sl};
			end
			check(np, rt[i][15:8]);
			check(nl, rt[i][7:0]);
		end
		$display("Frame rate done.");
		complete_run();
	end
endmodule
